// File: shared/csf_consts.vh
// Constants of the core: address map, status bits, encodings
`ifndef CSF_CONSTS_VH
`define CSF_CONSTS_VH
`define CSF_RF_LAST 16'h001F
`define CSF_IO_BASE 16'h0020
`define CSF_STATUS_IO 6'h3F
`define CSF_STATUS_RESET 8'h00
`define CSF_SP_RESET 16'hFFFF
`define CSF_PC_RESET 16'h0000
`define CSF_VEC_STRIDE 16'h0002
`define CSF_IRQ_N 8
`define CSF_B_GIE 7
`define CSF_B_COPY 6
`define CSF_B_HALF 5
`define CSF_B_SIGN 4
`define CSF_B_OVF 3
`define CSF_B_NEG 2
`define CSF_B_ZERO 1
`define CSF_B_CARRY 0
`define CSF_FLAG_MASK_ALL 6'h3F
`define CSF_FLAG_MASK_SVNZC 6'h1F
`define CSF_FLAG_MASK_SVNZ 6'h1E
`define CSF_PTR_X 5'h1A
`define CSF_PTR_Z 5'h1E
`define CSF_C_SUBI 4'h8
`define CSF_C_ANDI 4'h9
`define CSF_C_ORI 4'hA
`define CSF_C_LDI 4'hB
`define CSF_C_ONE 4'hC
`define CSF_C_MEM 4'hD
`define CSF_C_IO 4'hE
`define CSF_C_FLOW 4'hF
`define CSF_S_BIT_STORE 4'h8
`define CSF_S_BIT_LOAD 4'h9
`define CSF_S_IRQ_ENABLE 4'hA
`define CSF_S_IRQ_DISABLE 4'hB
`define CSF_S_IRQ_RETURN 4'hC
`define CSF_S_RET 4'hD
`define CSF_F_BRS 2'h0
`define CSF_F_BRC 2'h1
`define CSF_F_CALL 2'h2
`define CSF_F_JMP 2'h3
`define CSF_P_PROG 2'h3
`define CSF_OP_ADD 4'h0
`define CSF_OP_ADC 4'h1
`define CSF_OP_SUB 4'h2
`define CSF_OP_SBC 4'h3
`define CSF_OP_AND 4'h4
`define CSF_OP_OR 4'h5
`define CSF_OP_EOR 4'h6
`define CSF_OP_MOV 4'h7
`define CSF_OP_COM 4'h8
`define CSF_OP_NEG 4'h9
`define CSF_OP_INC 4'hA
`define CSF_OP_DEC 4'hB
`define CSF_OP_LSR 4'hC
`define CSF_OP_ROR 4'hD
`define CSF_OP_ASR 4'hE
`define CSF_OP_SWAP 4'hF
`endif

// File: logic/csf_alu.v
// Combinational ALU: result, flags and the mask of flags it affects
`timescale 1ns/10ps
`default_nettype none
`include "csf_consts.vh"
module csf_alu (
   input wire [3:0] i_op,
   input wire [7:0] i_a,
   input wire [7:0] i_b,
   input wire i_cin,
   output reg [7:0] o_res,
   output reg [5:0] o_flags,
   output reg [5:0] o_mask
);
   reg [9:0] t;
   reg h;
   reg c;
   reg v;

   // Returns {half carry, carry, result}; borrow semantics when subtracting
   function [9:0] addsub;
      input [7:0] a;
      input [7:0] b;
      input cin;
      input sub;
      reg [8:0] s;
      reg [4:0] hn;
      begin
         if (sub) begin
            s = {1'b0, a} - {1'b0, b} - {8'h00, cin};
            hn = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
         end else begin
            s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
            hn = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
         end
         addsub = {hn[4], s};
      end
   endfunction

   function ovf;
      input [7:0] a;
      input [7:0] b;
      input [7:0] r;
      input sub;
      begin
         if (sub)
            ovf = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
         else
            ovf = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
      end
   endfunction

   always @* begin
      t = 10'h000;
      o_res = i_a;
      h = 1'b0;
      c = i_cin;
      v = 1'b0;
      o_mask = 6'h00;
      case (i_op)
         `CSF_OP_ADD, `CSF_OP_ADC, `CSF_OP_SUB, `CSF_OP_SBC: begin
            t = addsub(i_a, i_b, i_op[0] & i_cin, i_op[1]);
            o_res = t[7:0];
            c = t[8];
            h = t[9];
            v = ovf(i_a, i_b, t[7:0], i_op[1]);
            o_mask = `CSF_FLAG_MASK_ALL;
         end
         `CSF_OP_AND: begin
            o_res = i_a & i_b;
            o_mask = `CSF_FLAG_MASK_SVNZ;
         end
         `CSF_OP_OR: begin
            o_res = i_a | i_b;
            o_mask = `CSF_FLAG_MASK_SVNZ;
         end
         `CSF_OP_EOR: begin
            o_res = i_a ^ i_b;
            o_mask = `CSF_FLAG_MASK_SVNZ;
         end
         `CSF_OP_MOV: o_res = i_b;
         `CSF_OP_COM: begin
            o_res = ~i_a;
            c = 1'b1;
            o_mask = `CSF_FLAG_MASK_SVNZC;
         end
         `CSF_OP_NEG: begin
            t = addsub(8'h00, i_a, 1'b0, 1'b1);
            o_res = t[7:0];
            c = t[8];
            h = t[9];
            v = ovf(8'h00, i_a, t[7:0], 1'b1);
            o_mask = `CSF_FLAG_MASK_ALL;
         end
         `CSF_OP_INC, `CSF_OP_DEC: begin
            t = addsub(i_a, 8'h01, 1'b0, i_op[0]);
            o_res = t[7:0];
            v = ovf(i_a, 8'h01, t[7:0], i_op[0]);
            o_mask = `CSF_FLAG_MASK_SVNZ;
         end
         `CSF_OP_LSR, `CSF_OP_ROR, `CSF_OP_ASR: begin
            o_res = {(i_op == `CSF_OP_ROR) ? i_cin : ((i_op == `CSF_OP_ASR) & i_a[7]), i_a[7:1]};
            c = i_a[0];
            v = o_res[7] ^ i_a[0];
            o_mask = `CSF_FLAG_MASK_SVNZC;
         end
         `CSF_OP_SWAP: o_res = {i_a[3:0], i_a[7:4]};
         default: o_res = i_a;
      endcase
      // Order: H S V N Z C, lined up with status bits 5..0
      o_flags = {h, o_res[7] ^ v, v, o_res[7], o_res == 8'h00, c};
   end
endmodule
`default_nettype wire

// File: logic/csf_core.v
// Execution core: register file, prefetch, pointers, status flags, interrupt entry
`timescale 1ns/10ps
`default_nettype none
`include "csf_consts.vh"
// How it works
// - Thirty-two 8-bit registers; ALU reads two, writes back in one clock.
// - Next instruction is fetched while the current one executes.
// - Registers 26..31 form three 16-bit pointers; Z also reads program memory.
// - Register and immediate ALU operations finish in one clock.
// - ALU operations other than MOV, LDI and SWAP update the status flags from their result.
// - Interrupt entry and return neither save nor restore the status register.
// - Status register sits at I/O 0x3F, data 0x5F, read/write, resets zero.
// - Bit 7 gates every interrupt; clear means none is taken.
// - Taking an interrupt clears bit 7; interrupt return sets it.
// - Dedicated instructions set and clear bit 7.
// - Bit 6 is the copy bit for bit-store and bit-load instructions.
// - Bit 5 holds the carry out of the low nibble.
// - Bit 4 is always negative xor overflow.
// - Bit 3 shows two's complement overflow.
// - Bit 2 is set on a negative result.
// - Bit 1 is set on a zero result.
// - Bit 0 is set on a carry.
// - 64 I/O addresses, reached directly or as data addresses 0x20..0x5F.
// - Lower interrupt vector means higher priority.
// - Return address is pushed onto the stack in data memory.
// - Instructions are one 16-bit word, some two; memory words are 16 bits.
// - Working registers appear at data addresses 0x00..0x1F.
module csf_core (
   input wire i_mclk,
   input wire i_nrst,
   output wire [15:0] o_pm_addr,
   input wire [15:0] i_pm_data,
   output wire [15:0] o_dm_addr,
   output wire [7:0] o_dm_wdata,
   output wire o_dm_we,
   output wire o_dm_re,
   input wire [7:0] i_dm_rdata,
   input wire [`CSF_IRQ_N-1:0] i_irq_req,
   output wire o_irq_ack,
   output wire [2:0] o_irq_num,
   output wire [7:0] o_core_status_flags
);
   localparam S_RUN = 4'h0;
   localparam S_JMP2 = 4'h1;
   localparam S_PUSHL = 4'h2;
   localparam S_PUSHH = 4'h3;
   localparam S_LDW = 4'h4;
   localparam S_LDD = 4'h5;
   localparam S_POP1 = 4'h6;
   localparam S_POP2 = 4'h7;
   localparam S_POP3 = 4'h8;
   localparam S_LPM1 = 4'h9;
   localparam S_LPM2 = 4'hA;

   reg [7:0] rf_ff [0:31];
   reg [15:0] pc_ff, nxt_pc;
   reg vld_ff, nxt_vld;
   reg [3:0] st_ff, nxt_st;
   reg [7:0] sr_ff, nxt_sr;
   reg [15:0] sp_ff, nxt_sp;
   reg [15:0] tgt_ff, nxt_tgt;
   reg [15:0] ret_ff, nxt_ret;
   reg [4:0] dst_ff, nxt_dst;
   reg hi_ff, nxt_hi;
   reg aux_ff, nxt_aux;
   reg [15:0] dma_ff, nxt_dma;
   reg [7:0] dmw_ff, nxt_dmw;
   reg dmwe_ff, nxt_dmwe;
   reg dmre_ff, nxt_dmre;
   reg ack_ff, nxt_ack;
   reg [2:0] irqn_ff, nxt_irqn;
   reg rf_we;
   reg [4:0] rf_wa;
   reg [7:0] rf_wd;
   reg pw_we;
   integer i;

   wire [15:0] ir = i_pm_data;
   wire [3:0] cls = ir[15:12];
   wire [3:0] sub = ir[11:8];
   wire [4:0] rd = ~cls[3] ? ir[9:5] : (cls < `CSF_C_ONE) ? {1'b1, ir[7:4]} : ir[4:0];
   wire [4:0] mr = ir[4:0];
   wire [7:0] imm = {ir[11:8], ir[3:0]};
   wire [2:0] bsel = ir[7:5];
   wire [3:0] imm_op = (cls == `CSF_C_SUBI) ? `CSF_OP_SUB : (cls == `CSF_C_ANDI) ? `CSF_OP_AND :
                       (cls == `CSF_C_ORI) ? `CSF_OP_OR : `CSF_OP_MOV;
   wire [3:0] aop = ~cls[3] ? {1'b0, ir[14:12]} : (cls == `CSF_C_ONE) ? {1'b1, sub[2:0]} : imm_op;
   wire alu_is = ~cls[3] | (cls < `CSF_C_ONE) | ((cls == `CSF_C_ONE) & ~sub[3]);
   wire [7:0] va = rf_ff[rd];
   wire [7:0] vb = cls[3] ? imm : rf_ff[mr];
   wire [1:0] psel = ir[10:9];
   wire [4:0] pidx = (psel == `CSF_P_PROG) ? `CSF_PTR_Z : `CSF_PTR_X + {2'b00, psel, 1'b0};
   wire [15:0] pv = {rf_ff[pidx + 5'h01], rf_ff[pidx]};
   wire [15:0] pv_inc = pv + 16'h0001;
   wire [15:0] ioa = `CSF_IO_BASE + {10'h000, ir[10:5]};
   wire [15:0] sr_da = `CSF_IO_BASE + {10'h000, `CSF_STATUS_IO};
   wire [15:0] da = (cls == `CSF_C_IO) ? ioa : pv;
   wire [15:0] boff = {{9{ir[6]}}, ir[6:0]};
   wire [7:0] alu_r;
   wire [5:0] alu_f;
   wire [5:0] alu_m;

   csf_alu u_alu (
      .i_op(aop),
      .i_a(va),
      .i_b(vb),
      .i_cin(sr_ff[`CSF_B_CARRY]),
      .o_res(alu_r),
      .o_flags(alu_f),
      .o_mask(alu_m)
   );

   // Data addresses below 0x20 hit the register file, not the bus
   function is_rf;
      input [15:0] a;
      begin
         is_rf = (a <= `CSF_RF_LAST);
      end
   endfunction

   // Lowest requesting line wins
   function [2:0] prio;
      input [`CSF_IRQ_N-1:0] req;
      integer k;
      begin
         prio = 3'h0;
         for (k = `CSF_IRQ_N - 1; k >= 0; k = k - 1) begin
            if (req[k])
               prio = k[2:0];
         end
      end
   endfunction

   always @* begin
      nxt_pc = pc_ff;
      nxt_vld = vld_ff;
      nxt_st = st_ff;
      nxt_sr = sr_ff;
      nxt_sp = sp_ff;
      nxt_tgt = tgt_ff;
      nxt_ret = ret_ff;
      nxt_dst = dst_ff;
      nxt_hi = hi_ff;
      nxt_aux = aux_ff;
      nxt_dma = dma_ff;
      nxt_dmw = dmw_ff;
      nxt_dmwe = 1'b0;
      nxt_dmre = 1'b0;
      nxt_ack = 1'b0;
      nxt_irqn = irqn_ff;
      rf_we = 1'b0;
      rf_wa = rd;
      rf_wd = alu_r;
      pw_we = 1'b0;
      case (st_ff)
         S_RUN: begin
            if (!vld_ff) begin
               nxt_pc = pc_ff + 16'h0001;
               nxt_vld = 1'b1;
            end else if (sr_ff[`CSF_B_GIE] && (|i_irq_req)) begin
               // Status is not stacked; the handler must save it itself
               nxt_ret = pc_ff - 16'h0001;
               nxt_tgt = `CSF_VEC_STRIDE * ({13'h0000, prio(i_irq_req)} + 16'h0001);
               nxt_sr[`CSF_B_GIE] = 1'b0;
               nxt_ack = 1'b1;
               nxt_irqn = prio(i_irq_req);
               nxt_st = S_PUSHL;
            end else begin
               nxt_pc = pc_ff + 16'h0001;
               if (alu_is) begin
                  rf_we = 1'b1;
                  nxt_sr[5:0] = (sr_ff[5:0] & ~alu_m) | (alu_f & alu_m);
               end
               case (cls)
                  `CSF_C_ONE: begin
                     case (sub)
                        `CSF_S_BIT_STORE: nxt_sr[`CSF_B_COPY] = va[bsel];
                        `CSF_S_BIT_LOAD: begin
                           rf_we = 1'b1;
                           rf_wd = (va & ~(8'h01 << bsel)) | ({7'h00, sr_ff[`CSF_B_COPY]} << bsel);
                        end
                        `CSF_S_IRQ_ENABLE: nxt_sr[`CSF_B_GIE] = 1'b1;
                        `CSF_S_IRQ_DISABLE: nxt_sr[`CSF_B_GIE] = 1'b0;
                        `CSF_S_IRQ_RETURN, `CSF_S_RET: begin
                           nxt_aux = (sub == `CSF_S_IRQ_RETURN);
                           nxt_dma = sp_ff + 16'h0001;
                           nxt_dmre = 1'b1;
                           nxt_sp = sp_ff + 16'h0001;
                           nxt_st = S_POP1;
                        end
                        default: nxt_aux = aux_ff;
                     endcase
                  end
                  `CSF_C_MEM, `CSF_C_IO: begin
                     if ((cls == `CSF_C_MEM) && (psel == `CSF_P_PROG)) begin
                        // Table read steals the fetch port, so the next word is refetched
                        nxt_pc = {1'b0, pv[15:1]};
                        nxt_hi = pv[0];
                        nxt_tgt = pc_ff;
                        nxt_dst = mr;
                        pw_we = ir[8];
                        nxt_st = S_LPM1;
                     end else if (ir[11]) begin
                        pw_we = (cls == `CSF_C_MEM) & ir[8];
                        if (is_rf(da)) begin
                           rf_we = 1'b1;
                           rf_wa = da[4:0];
                           rf_wd = rf_ff[mr];
                        end else if (da == sr_da) begin
                           nxt_sr = rf_ff[mr];
                        end else begin
                           nxt_dmwe = 1'b1;
                           nxt_dma = da;
                           nxt_dmw = rf_ff[mr];
                        end
                     end else begin
                        pw_we = (cls == `CSF_C_MEM) & ir[8];
                        rf_wa = mr;
                        if (is_rf(da)) begin
                           rf_we = 1'b1;
                           rf_wd = rf_ff[da[4:0]];
                        end else if (da == sr_da) begin
                           rf_we = 1'b1;
                           rf_wd = sr_ff;
                        end else begin
                           nxt_dmre = 1'b1;
                           nxt_dma = da;
                           nxt_dst = mr;
                           nxt_tgt = pc_ff;
                           nxt_st = S_LDW;
                        end
                     end
                  end
                  `CSF_C_FLOW: begin
                     case (ir[11:10])
                        `CSF_F_BRS, `CSF_F_BRC: begin
                           if (sr_ff[ir[9:7]] == ~ir[10]) begin
                              nxt_pc = pc_ff + boff;
                              nxt_vld = 1'b0;
                           end
                        end
                        default: begin
                           // Second word is the target; it arrives next cycle
                           nxt_aux = (ir[11:10] == `CSF_F_CALL);
                           nxt_st = S_JMP2;
                        end
                     endcase
                  end
                  default: nxt_aux = aux_ff;
               endcase
            end
         end
         S_JMP2: begin
            nxt_ret = pc_ff;
            if (aux_ff) begin
               nxt_tgt = ir;
               nxt_st = S_PUSHL;
            end else begin
               nxt_pc = ir;
               nxt_vld = 1'b0;
               nxt_st = S_RUN;
            end
         end
         S_PUSHL: begin
            nxt_dmwe = 1'b1;
            nxt_dma = sp_ff;
            nxt_dmw = ret_ff[7:0];
            nxt_sp = sp_ff - 16'h0001;
            nxt_st = S_PUSHH;
         end
         S_PUSHH: begin
            nxt_dmwe = 1'b1;
            nxt_dma = sp_ff;
            nxt_dmw = ret_ff[15:8];
            nxt_sp = sp_ff - 16'h0001;
            nxt_pc = tgt_ff;
            nxt_vld = 1'b0;
            nxt_st = S_RUN;
         end
         S_LDW: nxt_st = S_LDD;
         S_LDD: begin
            rf_we = 1'b1;
            rf_wa = dst_ff;
            rf_wd = i_dm_rdata;
            nxt_pc = tgt_ff;
            nxt_vld = 1'b0;
            nxt_st = S_RUN;
         end
         S_POP1: begin
            nxt_dma = sp_ff + 16'h0001;
            nxt_dmre = 1'b1;
            nxt_sp = sp_ff + 16'h0001;
            nxt_st = S_POP2;
         end
         S_POP2: begin
            nxt_tgt = {i_dm_rdata, tgt_ff[7:0]};
            nxt_st = S_POP3;
         end
         S_POP3: begin
            nxt_pc = {tgt_ff[15:8], i_dm_rdata};
            nxt_vld = 1'b0;
            if (aux_ff)
               nxt_sr[`CSF_B_GIE] = 1'b1;
            nxt_st = S_RUN;
         end
         S_LPM1: nxt_st = S_LPM2;
         S_LPM2: begin
            rf_we = 1'b1;
            rf_wa = dst_ff;
            rf_wd = hi_ff ? ir[15:8] : ir[7:0];
            nxt_pc = tgt_ff;
            nxt_vld = 1'b0;
            nxt_st = S_RUN;
         end
         default: nxt_st = S_RUN;
      endcase
   end

   always @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         for (i = 0; i < 32; i = i + 1)
            rf_ff[i] <= 8'h00;
         pc_ff <= `CSF_PC_RESET;
         vld_ff <= 1'b0;
         st_ff <= S_RUN;
         sr_ff <= `CSF_STATUS_RESET;
         sp_ff <= `CSF_SP_RESET;
         tgt_ff <= 16'h0000;
         ret_ff <= 16'h0000;
         dst_ff <= 5'h00;
         hi_ff <= 1'b0;
         aux_ff <= 1'b0;
         dma_ff <= 16'h0000;
         dmw_ff <= 8'h00;
         dmwe_ff <= 1'b0;
         dmre_ff <= 1'b0;
         ack_ff <= 1'b0;
         irqn_ff <= 3'h0;
      end else begin
         // Pointer update first so a load into the pointer itself wins
         if (pw_we) begin
            rf_ff[pidx] <= pv_inc[7:0];
            rf_ff[pidx + 5'h01] <= pv_inc[15:8];
         end
         if (rf_we)
            rf_ff[rf_wa] <= rf_wd;
         pc_ff <= nxt_pc;
         vld_ff <= nxt_vld;
         st_ff <= nxt_st;
         sr_ff <= nxt_sr;
         sp_ff <= nxt_sp;
         tgt_ff <= nxt_tgt;
         ret_ff <= nxt_ret;
         dst_ff <= nxt_dst;
         hi_ff <= nxt_hi;
         aux_ff <= nxt_aux;
         dma_ff <= nxt_dma;
         dmw_ff <= nxt_dmw;
         dmwe_ff <= nxt_dmwe;
         dmre_ff <= nxt_dmre;
         ack_ff <= nxt_ack;
         irqn_ff <= nxt_irqn;
      end
   end

   assign o_pm_addr = pc_ff;
   assign o_dm_addr = dma_ff;
   assign o_dm_wdata = dmw_ff;
   assign o_dm_we = dmwe_ff;
   assign o_dm_re = dmre_ff;
   assign o_irq_ack = ack_ff;
   assign o_irq_num = irqn_ff;
   assign o_core_status_flags = sr_ff;
endmodule
`default_nettype wire

// File: sim/csf_core_assertions.sv
// Port checker for the execution core
`timescale 1ns/10ps
`default_nettype none
`include "csf_consts.vh"
module csf_core_assertions (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic [15:0] o_pm_addr,
   input wire logic [15:0] o_dm_addr,
   input wire logic o_dm_we,
   input wire logic o_dm_re,
   input wire logic [`CSF_IRQ_N-1:0] i_irq_req,
   input wire logic o_irq_ack,
   input wire logic [2:0] o_irq_num,
   input wire logic [7:0] o_core_status_flags
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);

   // Reset itself is the cause here, so it must not disable the check
   a_reset_status_zero: assert property (disable iff (1'b0) !i_nrst |-> o_core_status_flags == 8'h00)
      else $error("status not zero during reset");
   a_gie_gates_irq: assert property (o_irq_ack |-> $past(o_core_status_flags[7]))
      else $error("interrupt taken with global enable clear");
   a_gie_cleared_entry: assert property (o_irq_ack |-> !o_core_status_flags[7])
      else $error("global enable still set after entry");
   a_ack_one_pulse: assert property (o_irq_ack |=> !o_irq_ack)
      else $error("acknowledge longer than one cycle");
   a_irq_priority_low: assert property (o_irq_ack |-> (($past(i_irq_req) & (8'h01 << o_irq_num)) != 8'h00) &&
      ((((8'h01 << o_irq_num) - 8'h01) & $past(i_irq_req)) == 8'h00))
      else $error("taken line not the highest priority request");
   a_vector_fetch_addr: assert property (o_irq_ack |-> ##[1:4]
      o_pm_addr == {11'h000, {1'b0, o_irq_num} + 4'h1, 1'b0})
      else $error("vector not fetched");
   a_return_push_pair: assert property (o_irq_ack |=> o_dm_we ##1
      (o_dm_we && o_dm_addr == $past(o_dm_addr) - 16'h0001))
      else $error("return address not pushed as two bytes");
   a_flags_kept_entry: assert property (o_irq_ack |->
      ((o_core_status_flags ^ $past(o_core_status_flags)) & 8'h7F) == 8'h00)
      else $error("flags changed on interrupt entry");
   a_bus_skips_internal: assert property ((o_dm_we || o_dm_re) |->
      o_dm_addr > 16'h001F && o_dm_addr != 16'h005F)
      else $error("internal location driven on the data bus");

   c_second_irq: cover property (o_irq_ack && o_irq_num == 3'd5);
   c_ext_read: cover property (o_dm_re);
   c_ext_store: cover property (o_dm_we && o_dm_addr == 16'h0060);
endmodule

bind csf_core csf_core_assertions i_chk (
   .i_mclk(i_mclk),
   .i_nrst(i_nrst),
   .o_pm_addr(o_pm_addr),
   .o_dm_addr(o_dm_addr),
   .o_dm_we(o_dm_we),
   .o_dm_re(o_dm_re),
   .i_irq_req(i_irq_req),
   .o_irq_ack(o_irq_ack),
   .o_irq_num(o_irq_num),
   .o_core_status_flags(o_core_status_flags)
);
`default_nettype wire

// File: sim/csf_mem_model.sv
// Program and data memory model facing the core
`timescale 1ns/10ps
`default_nettype none
module csf_mem_model (
   input wire logic i_mclk,
   input wire logic [15:0] i_pm_addr,
   output logic [15:0] o_pm_data,
   input wire logic [15:0] i_dm_addr,
   input wire logic [7:0] i_dm_wdata,
   input wire logic i_dm_we,
   input wire logic i_dm_re,
   output logic [7:0] o_dm_rdata
);
   logic [15:0] prog [0:255];
   logic [7:0] dmem [0:65535];
   initial begin
      o_pm_data = 16'h0000;
      o_dm_rdata = 8'h00;
   end
   // Same-clock memories: answer lands the cycle after the request
   always @(posedge i_mclk) begin
      o_pm_data <= prog[i_pm_addr[7:0]];
      if (i_dm_we) begin
         dmem[i_dm_addr] <= i_dm_wdata;
      end
      // Lines not held outside a read, so a late sample cannot pass
      o_dm_rdata <= i_dm_re ? dmem[i_dm_addr] : ~o_dm_rdata;
   end
endmodule
`default_nettype wire

// File: sim/csf_core_tb_top.sv
// Bench: runs a small program and checks what reaches data space
`timescale 1ns/10ps
`default_nettype none
module csf_core_tb_top;
   logic i_mclk = 1'b0;
   logic i_nrst = 1'b0;
   logic [7:0] irq_req = 8'h28;
   wire [15:0] pm_addr;
   wire [15:0] pm_data;
   wire [15:0] dm_addr;
   wire [7:0] dm_wdata;
   wire dm_we;
   wire dm_re;
   wire [7:0] dm_rdata;
   wire irq_ack;
   wire [2:0] irq_num;
   wire [7:0] status;
   int bad_count = 0;
   int num_checks = 0;
   int wr_idx = 0;
   int acks = 0;
   int pushes = 0;
   // Main code from word 0x10; results copied out through I/O space and through pointer X at 0x60..0x61
   localparam logic [15:0] main_img [0:33] = '{
      16'hB70F, 16'hB011, 16'h0211, 16'hE7F2, 16'hE812, 16'h0210, 16'hE7F2, 16'hE812,
      16'hB555, 16'hEFF5, 16'hE7F2, 16'hE812, 16'hC9F0, 16'hC810, 16'hE7F2, 16'hE812,
      16'hE810, 16'hB6A0, 16'hB0B0, 16'hD910, 16'hD811, 16'hD013, 16'hE873, 16'hB1A5,
      16'hD014, 16'hE894, 16'hCA00, 16'hE7F2, 16'hE812, 16'hCB00, 16'hE7F2, 16'hE812,
      16'hFC00, 16'h0030};
   // Expected writes, address then byte
   localparam logic [23:0] exp_wr [0:11] = '{
      24'h00202C,
      24'h00201B,
      24'h002055,
      24'h002015,
      24'h002080,
      24'h006080,
      24'h006101,
      24'h002301,
      24'h002455,
      24'h002115,
      24'h002095,
      24'h002015};
   localparam logic [2:0] exp_num [0:1] = '{3'd3, 3'd5};

   csf_core i_dut (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .o_pm_addr(pm_addr),
      .i_pm_data(pm_data),
      .o_dm_addr(dm_addr),
      .o_dm_wdata(dm_wdata),
      .o_dm_we(dm_we),
      .o_dm_re(dm_re),
      .i_dm_rdata(dm_rdata),
      .i_irq_req(irq_req),
      .o_irq_ack(irq_ack),
      .o_irq_num(irq_num),
      .o_core_status_flags(status)
   );
   csf_mem_model i_mem (
      .i_mclk(i_mclk),
      .i_pm_addr(pm_addr),
      .o_pm_data(pm_data),
      .i_dm_addr(dm_addr),
      .i_dm_wdata(dm_wdata),
      .i_dm_we(dm_we),
      .i_dm_re(dm_re),
      .o_dm_rdata(dm_rdata)
   );

   always #5 i_mclk = ~i_mclk;

   task check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask

   task tally_and_finish;
      $display("Checks %0d, mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge i_mclk) begin
      if (dm_we && dm_addr < 16'hFF00) begin
         check({dm_addr, dm_wdata} === exp_wr[wr_idx], "data write differs");
         wr_idx++;
      end
      if (dm_we && dm_addr >= 16'hFF00) begin
         check(dm_addr[15:1] === 15'h7FFF, "stack write address");
         pushes++;
      end
      if (irq_ack) begin
         check(irq_num === exp_num[acks], "taken line");
         acks++;
         // Request level dropped once served, as a peripheral would
         #1 irq_req[irq_num] = 1'b0;
      end
   end

   initial begin
      i_mem.prog[0] = 16'hFC00;
      i_mem.prog[1] = 16'h0010;
      i_mem.prog[8] = 16'hE7F2;
      i_mem.prog[9] = 16'hE832;
      i_mem.prog[10] = 16'hCC00;
      i_mem.prog[12] = 16'hCC00;
      for (int k = 0; k < 34; k++) begin
         i_mem.prog[16 + k] = main_img[k];
      end
      repeat (3) @(posedge i_mclk);
      #1;
      check(status === 8'h00 && pm_addr === 16'h0000, "reset state");
      i_nrst = 1'b1;
      for (int n = 0; n < 3000 && wr_idx < 12; n++) begin
         @(posedge i_mclk);
      end
      check(wr_idx === 12, "program did not finish");
      repeat (20) @(posedge i_mclk);
      check(acks === 2 && pushes === 4, "interrupt entries");
      tally_and_finish;
   end
endmodule
`default_nettype wire
